// ### design/cspc_pkg.sv
// package for the clock synth program controller: register map, fields, timing
// assumes a 32-bit apb slave clocked by pclk at 40 MHz
package cspc_pkg;
  localparam logic [7:0]  CSPC_OFS_INDEX    = 8'ha0;
  localparam logic [7:0]  CSPC_OFS_MEM_ONE  = 8'ha4;
  localparam logic [7:0]  CSPC_OFS_CMD_STAT = 8'ha8;
  localparam logic [7:0]  CSPC_OFS_MEM_TWO  = 8'hac;
  localparam logic [7:0]  CSPC_OFS_IRQ_STAT = 8'hb0;
  localparam logic [7:0]  CSPC_OFS_IRQ_EN   = 8'hb4;
  localparam logic [7:0]  CSPC_OFS_IRQ_CLR  = 8'hb8;
  // control word fields
  localparam int CSPC_B_PROG    = 0;
  localparam int CSPC_B_MSEL_LO = 1;
  localparam int CSPC_B_RBSEL   = 6;
  localparam int CSPC_B_DIVSET  = 7;
  localparam int CSPC_DIV_LO    = 8;
  localparam int CSPC_DIV_W     = 4;
  localparam int CSPC_NCH       = 4;
  // status word fields
  localparam int CSPC_S_DONE    = 0;
  localparam int CSPC_S_ERR     = 1;
  localparam int CSPC_S_MDONE   = 2;
  localparam int CSPC_S_VAL_LO  = 8;
  // setting memory
  localparam int          CSPC_MEM_DEPTH = 256;
  localparam logic [7:0]  CSPC_LOAD_FIRST = 8'h08;
  localparam logic [7:0]  CSPC_LOAD_LAST  = 8'h57;
  // timing: serial bit rate and measurement gate length in pclk cycles
  localparam int CSPC_CLK_HZ      = 40_000_000;
  localparam int CSPC_SER_HZ      = 400_000;
  localparam int CSPC_SER_HALF    = CSPC_CLK_HZ / (2 * CSPC_SER_HZ);
  localparam int CSPC_GATE_US     = 10;
  localparam int CSPC_GATE_CYC    = CSPC_CLK_HZ / 1_000_000 * CSPC_GATE_US;
  localparam logic [6:0] CSPC_CHIP_ADDR = 7'h69; // arbitrary serial address
  // interrupt bits
  localparam int CSPC_I_LOAD  = 0;
  localparam int CSPC_I_ERR   = 1;
  localparam int CSPC_I_MEAS  = 2;
  localparam int CSPC_I_W     = 3;
  typedef enum logic [2:0] {
    CSPC_S_IDLE  = 3'b000,
    CSPC_S_START = 3'b001,
    CSPC_S_BITS  = 3'b010,
    CSPC_S_ACK   = 3'b011,
    CSPC_S_STOP  = 3'b100
  } cspc_ser_t;
endpackage

// ### design/cspc_top.sv
// clock synth program controller: two setting memories, serial loader,
// power-of-two channel post-dividers and channel clock frequency meter
// assumes apb master on pclk; channel clocks sampled synchronous to pclk
`timescale 1ns/1ps
module cspc_top
  import cspc_pkg::*;
#(
  parameter int GATE_CYC = CSPC_GATE_CYC,
  parameter int SER_HALF = CSPC_SER_HALF
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [2:0]  generator_output_abc,
  input  wire logic        generator_output_d,
  output logic      [3:0]  channel_clock,
  output logic      [1:0]  ser_clk,
  input  wire logic [1:0]  ser_data_in,
  output logic      [1:0]  ser_data_out,
  output logic      [1:0]  ser_data_oe,
  output logic             irq
);
  logic [7:0]  mem_one [CSPC_MEM_DEPTH];
  logic [7:0]  mem_two [CSPC_MEM_DEPTH];
  logic [7:0]  index_r;
  logic [23:0] ctrl_r;
  logic [CSPC_DIV_W*CSPC_NCH-1:0] div_r;
  logic        done_r, err_r, mdone_r;
  logic [23:0] meas_r;
  logic [CSPC_I_W-1:0] ist_r, ien_r;
  logic        wr, rd;
  logic        load_go;

  // apb decode, zero wait state
  assign wr      = psel & penable & pwrite;
  assign rd      = psel & penable & ~pwrite;
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~(paddr == CSPC_OFS_INDEX || paddr == CSPC_OFS_MEM_ONE ||
                   paddr == CSPC_OFS_CMD_STAT || paddr == CSPC_OFS_MEM_TWO ||
                   paddr == CSPC_OFS_IRQ_STAT || paddr == CSPC_OFS_IRQ_EN ||
                   paddr == CSPC_OFS_IRQ_CLR);
  assign load_go = wr && paddr == CSPC_OFS_CMD_STAT && pwdata[CSPC_B_PROG] && done_r;

  // index register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      index_r <= 8'h00;
    end else if (wr && paddr == CSPC_OFS_INDEX) begin
      index_r <= pwdata[7:0];
    end
  end

  // setting memories, only the low byte of each write is stored
  always_ff @(posedge pclk) begin
    if (wr && paddr == CSPC_OFS_MEM_ONE) begin
      mem_one[index_r] <= pwdata[7:0];
    end
    if (wr && paddr == CSPC_OFS_MEM_TWO) begin
      mem_two[index_r] <= pwdata[7:0];
    end
  end

  // control word; program bit is never stored so it reads back as zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r <= 24'h000000;
      div_r  <= '0;
    end else if (wr && paddr == CSPC_OFS_CMD_STAT) begin
      ctrl_r <= {pwdata[23:1], 1'b0};
      if (pwdata[CSPC_B_DIVSET]) begin
        div_r <= pwdata[CSPC_DIV_LO +: CSPC_DIV_W*CSPC_NCH];
      end
    end
  end

  // read mux
  always_comb begin
    prdata = 32'h00000000;
    if (rd) begin
      unique case (paddr)
        CSPC_OFS_INDEX:    prdata = {24'h000000, index_r};
        CSPC_OFS_MEM_ONE:  prdata = {24'h000000, mem_one[index_r]};
        CSPC_OFS_MEM_TWO:  prdata = {24'h000000, mem_two[index_r]};
        CSPC_OFS_CMD_STAT: prdata = {ctrl_r[CSPC_B_RBSEL] ? ctrl_r : meas_r,
                                     5'h00, mdone_r, err_r, done_r};
        CSPC_OFS_IRQ_STAT: prdata = {29'h0, ist_r};
        CSPC_OFS_IRQ_EN:   prdata = {29'h0, ien_r};
        default:           prdata = 32'h00000000;
      endcase
    end
  end

  // post-dividers: free counter per channel, output is bit n-1 (n=0 passes)
  logic [3:0]  gen_clk;
  logic [3:0]  gen_d;
  logic [14:0] dcnt [CSPC_NCH];
  assign gen_clk = {generator_output_d, generator_output_abc};
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gen_d <= 4'h0;
      for (int i = 0; i < CSPC_NCH; i++) dcnt[i] <= 15'h0000;
    end else begin
      gen_d <= gen_clk;
      for (int i = 0; i < CSPC_NCH; i++) begin
        if (gen_clk[i] && !gen_d[i]) dcnt[i] <= dcnt[i] + 15'h0001;
      end
    end
  end
  always_comb begin
    for (int i = 0; i < CSPC_NCH; i++) begin
      if (div_r[i*CSPC_DIV_W +: CSPC_DIV_W] == 4'h0) channel_clock[i] = gen_clk[i];
      else channel_clock[i] = dcnt[i][div_r[i*CSPC_DIV_W +: CSPC_DIV_W] - 4'h1];
    end
  end

  // frequency meter: count rising edges of selected channel over gate
  logic [3:0]  msel;
  logic        mclk_d;
  logic        mclk_now;
  logic        mrun;
  logic        meas_go;
  logic [31:0] gate_cnt;
  logic [23:0] edge_cnt;
  assign msel     = ctrl_r[CSPC_B_MSEL_LO +: CSPC_NCH];
  assign mclk_now = |(msel & channel_clock);
  // any select bit in a control write restarts the gate
  assign meas_go  = wr && paddr == CSPC_OFS_CMD_STAT && |pwdata[CSPC_B_MSEL_LO +: CSPC_NCH];
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mrun     <= 1'b0;
      mdone_r  <= 1'b0;
      mclk_d   <= 1'b0;
      gate_cnt <= 32'h0;
      edge_cnt <= 24'h0;
      meas_r   <= 24'h0;
    end else begin
      mclk_d <= mclk_now;
      if (meas_go) begin
        // seed the detector from the new selection so a high clock is no false edge
        mclk_d   <= |(pwdata[CSPC_B_MSEL_LO +: CSPC_NCH] & channel_clock);
        mrun     <= 1'b1;
        mdone_r  <= 1'b0;
        gate_cnt <= 32'h0;
        edge_cnt <= 24'h0;
      end else if (mrun) begin
        if (mclk_now && !mclk_d) edge_cnt <= edge_cnt + 24'h1;
        gate_cnt <= gate_cnt + 32'h1;
        if (gate_cnt == 32'(GATE_CYC - 1)) begin
          // the edge seen in the last gate cycle still belongs to the window
          mrun    <= 1'b0;
          mdone_r <= 1'b1;
          meas_r  <= edge_cnt + {23'h0, mclk_now && !mclk_d};
        end
      end
    end
  end

  // serial loader: byte writes of locations 08..57 to each chip in turn
  cspc_ser_t   st_r;
  logic        chip_r;
  logic [7:0]  addr_r;
  logic [1:0]  phase_r;
  logic [3:0]  bit_r;
  logic [7:0]  sh_r;
  logic [15:0] tq_r;
  logic        sclk_r;
  logic        sdo_r;
  logic        soe_r;
  logic        tick;
  assign tick = tq_r == 16'(SER_HALF - 1);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r    <= CSPC_S_IDLE;
      chip_r  <= 1'b0;
      addr_r  <= 8'h00;
      phase_r <= 2'b00;
      bit_r   <= 4'h0;
      sh_r    <= 8'h00;
      tq_r    <= 16'h0;
      sclk_r  <= 1'b1;
      sdo_r   <= 1'b1;
      soe_r   <= 1'b0;
      done_r  <= 1'b1;
      err_r   <= 1'b0;
    end else begin
      tq_r <= tick ? 16'h0 : tq_r + 16'h1;
      if (load_go) begin
        st_r    <= CSPC_S_START;
        chip_r  <= 1'b0;
        addr_r  <= CSPC_LOAD_FIRST;
        phase_r <= 2'b00;
        done_r  <= 1'b0;
        err_r   <= 1'b0;
      end else if (tick) begin
        unique case (st_r)
          CSPC_S_IDLE: begin
            sclk_r <= 1'b1;
            soe_r  <= 1'b0;
          end
          // start: data falls while the clock stands high
          CSPC_S_START: begin
            soe_r   <= 1'b1;
            sdo_r   <= 1'b0;
            sclk_r  <= 1'b1;
            bit_r   <= 4'h0;
            sh_r    <= {CSPC_CHIP_ADDR, 1'b0};
            phase_r <= 2'b00;
            st_r    <= CSPC_S_BITS;
          end
          // data changes as the clock falls, most significant bit first
          CSPC_S_BITS: begin
            sclk_r <= ~sclk_r;
            if (sclk_r) begin
              soe_r <= 1'b1;
              sdo_r <= sh_r[7];
              sh_r  <= {sh_r[6:0], 1'b0};
              bit_r <= bit_r + 4'h1;
            end else if (bit_r == 4'h8) begin
              st_r <= CSPC_S_ACK;
            end
          end
          // line released for one clock, answer sampled just before the clock rises
          CSPC_S_ACK: begin
            sclk_r <= ~sclk_r;
            if (sclk_r) begin
              soe_r <= 1'b0;
            end else begin
              if (ser_data_in[chip_r]) err_r <= 1'b1;
              bit_r   <= 4'h0;
              phase_r <= phase_r + 2'b01;
              sh_r    <= (phase_r == 2'b00) ? addr_r :
                         (chip_r ? mem_two[addr_r] : mem_one[addr_r]);
              st_r    <= (phase_r == 2'b10) ? CSPC_S_STOP : CSPC_S_BITS;
            end
          end
          // stop: clock low with data low, then clock high, then data rises
          // the chip drops its acknowledge only after the clock falls, hence three steps
          CSPC_S_STOP: begin
            soe_r <= 1'b1;
            bit_r <= bit_r + 4'h1;
            if (bit_r == 4'h0) begin
              sclk_r <= 1'b0;
              sdo_r  <= 1'b0;
            end else if (bit_r == 4'h1) begin
              sclk_r <= 1'b1;
            end else begin
              sdo_r <= 1'b1;
              if (addr_r != CSPC_LOAD_LAST) begin
                addr_r <= addr_r + 8'h01;
                st_r   <= CSPC_S_START;
              end else if (!chip_r) begin
                chip_r <= 1'b1;
                addr_r <= CSPC_LOAD_FIRST;
                st_r   <= CSPC_S_START;
              end else begin
                st_r   <= CSPC_S_IDLE;
                done_r <= 1'b1;
                soe_r  <= 1'b0;
              end
            end
          end
          default: st_r <= CSPC_S_IDLE;
        endcase
      end
    end
  end
  assign ser_clk      = chip_r ? {sclk_r, 1'b1} : {1'b1, sclk_r};
  assign ser_data_out = chip_r ? {sdo_r, 1'b1} : {1'b1, sdo_r};
  assign ser_data_oe  = chip_r ? {soe_r & ~sdo_r, 1'b0} : {1'b0, soe_r & ~sdo_r};

  // interrupt status: sticky, set wins over clear
  logic done_d, err_d, mdone_d;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ist_r   <= '0;
      ien_r   <= '0;
      done_d  <= 1'b1;
      err_d   <= 1'b0;
      mdone_d <= 1'b0;
    end else begin
      done_d  <= done_r;
      err_d   <= err_r;
      mdone_d <= mdone_r;
      if (wr && paddr == CSPC_OFS_IRQ_EN) ien_r <= pwdata[CSPC_I_W-1:0];
      ist_r <= (ist_r & ~((wr && paddr == CSPC_OFS_IRQ_CLR) ? pwdata[CSPC_I_W-1:0] : 3'b000))
               | {mdone_r & ~mdone_d, err_r & ~err_d, done_r & ~done_d};
    end
  end
  assign irq = |(ist_r & ien_r);

  // loader checks: start, busy, error and address window
  AST_PROG_CLEARS: assert property (@(posedge pclk) disable iff (!presetn)
    load_go |=> !done_r)
    else $error("load did not start");
  AST_CTRL_NO_PROG: assert property (@(posedge pclk) disable iff (!presetn)
    !ctrl_r[CSPC_B_PROG])
    else $error("program bit stored");
  AST_BUSY_IGNORED: assert property (@(posedge pclk) disable iff (!presetn)
    (wr && paddr == CSPC_OFS_CMD_STAT && pwdata[CSPC_B_PROG] && !done_r &&
     st_r != CSPC_S_STOP) |=> !done_r)
    else $error("program accepted while busy");
  AST_ACK_ERR: assert property (@(posedge pclk) disable iff (!presetn)
    (tick && st_r == CSPC_S_ACK && !sclk_r && ser_data_in[chip_r] && !load_go) |=> err_r)
    else $error("missing acknowledge not flagged");
  AST_ERR_STICKY: assert property (@(posedge pclk) disable iff (!presetn)
    (err_r && !load_go) |=> err_r)
    else $error("error flag dropped");
  AST_IDLE_DONE: assert property (@(posedge pclk) disable iff (!presetn)
    (st_r == CSPC_S_IDLE && !load_go) |-> done_r)
    else $error("idle not done");
  AST_LOAD_RANGE: assert property (@(posedge pclk) disable iff (!presetn)
    (st_r != CSPC_S_IDLE) |-> (addr_r >= CSPC_LOAD_FIRST && addr_r <= CSPC_LOAD_LAST))
    else $error("load location outside window");

  // divider, register and measurement checks
  AST_DIV_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
    (wr && paddr == CSPC_OFS_CMD_STAT && !pwdata[CSPC_B_DIVSET]) |=> $stable(div_r))
    else $error("divider changed without set");
  AST_DIV_LOAD: assert property (@(posedge pclk) disable iff (!presetn)
    (wr && paddr == CSPC_OFS_CMD_STAT && pwdata[CSPC_B_DIVSET]) |=>
    div_r == $past(pwdata[23:8]))
    else $error("divider not loaded");
  AST_MEAS_BUSY: assert property (@(posedge pclk) disable iff (!presetn)
    mrun |-> !mdone_r)
    else $error("measure done while running");
  AST_MEAS_LATCH: assert property (@(posedge pclk) disable iff (!presetn)
    (mrun && !meas_go && gate_cnt == 32'(GATE_CYC - 1)) |=> (mdone_r && !mrun))
    else $error("measurement not latched at gate end");
  AST_RB_SEL: assert property (@(posedge pclk) disable iff (!presetn)
    (rd && paddr == CSPC_OFS_CMD_STAT) |->
    prdata[31:8] == (ctrl_r[CSPC_B_RBSEL] ? ctrl_r : meas_r))
    else $error("readback");
  AST_INDEX: assert property (@(posedge pclk) disable iff (!presetn)
    (wr && paddr == CSPC_OFS_INDEX) |=> index_r == $past(pwdata[7:0]))
    else $error("index not stored");

  // main scenarios
  COV_LOAD: cover property (@(posedge pclk) disable iff (!presetn) $rose(done_r));
  COV_ERR: cover property (@(posedge pclk) disable iff (!presetn) $rose(err_r));
  COV_MEAS: cover property (@(posedge pclk) disable iff (!presetn) $rose(mdone_r));
  COV_DIV_SET: cover property (@(posedge pclk) disable iff (!presetn)
    wr && paddr == CSPC_OFS_CMD_STAT && pwdata[CSPC_B_DIVSET]);
  COV_RB_CTRL: cover property (@(posedge pclk) disable iff (!presetn)
    rd && paddr == CSPC_OFS_CMD_STAT && ctrl_r[CSPC_B_RBSEL]);
endmodule

// ### dv/cspc_chip_model.sv
// serial clock generator chip model: acknowledges every byte unless told to refuse
// assumes an open-drain data line with a pull-up, resolved by the bench
`timescale 1ns/1ps
module cspc_chip_model (
  input  wire logic       scl,
  input  wire logic       sda,
  input  wire logic       nack,
  output logic            pull,
  output logic [7:0]      first_byte,
  output logic [7:0]      last_byte,
  output logic [31:0]     frames
);
  logic       busy;
  int         nf;
  logic [7:0] sh;
  initial begin
    pull = 1'b0;
    busy = 1'b0;
    nf = 0;
    frames = 32'h0;
  end
  // start condition opens a frame, stop condition closes it; the short wait lets a
  // clock that falls in the same step as the data settle, so that is no condition
  always @(negedge sda) begin
    #1;
    if (scl === 1'b1 && sda === 1'b0) begin
      busy = 1'b1;
      nf = 0;
    end
  end
  always @(posedge sda) begin
    #1;
    if (scl === 1'b1 && sda === 1'b1 && busy) begin
      busy = 1'b0;
      frames = frames + 1;
    end
  end
  // data bits shift in on the rising clock, the ninth slot is skipped
  always @(posedge scl) if (busy && nf % 9 != 0) sh <= {sh[6:0], sda};
  // pull the line low through each acknowledge slot, keep address and data bytes
  always @(negedge scl) if (busy) begin
    nf = nf + 1;
    pull <= (nf % 9 == 0) && !nack;
    if (nf == 9) first_byte <= sh;
    if (nf == 27) last_byte <= sh;
  end
endmodule

// ### dv/tb.sv
// testbench: registers, loading, dividers, measurement and interrupts
// assumes two chip models on the serial lines and one slow generator clock
`timescale 1ns/1ps
module tb;
  import cspc_pkg::*;
  localparam int GATE = 96;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, e, gclk;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, q;
  logic [3:0]  chclk;
  logic [1:0]  scl, sdo, oe, sda, nack;
  wire  [1:0]  pull;
  wire  [7:0]  fb [2], lb [2];
  wire  [31:0] frames [2];
  int          err_count, n_compared, gcnt;
  cspc_top #(.GATE_CYC(GATE), .SER_HALF(2)) dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .generator_output_abc({3{gclk}}), .generator_output_d(gclk), .channel_clock(chclk),
    .ser_clk(scl), .ser_data_in(sda), .ser_data_out(sdo), .ser_data_oe(oe), .irq(irq));
  // wired-and of both pull-downs on each data line
  assign sda = ~(oe | pull);
  for (genvar i = 0; i < 2; i++) begin : g_chip
    cspc_chip_model model (.scl(scl[i]), .sda(sda[i]), .nack(nack[i]), .pull(pull[i]),
      .first_byte(fb[i]), .last_byte(lb[i]), .frames(frames[i]));
  end
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  // generator clock with a period of 8 pclk cycles
  always @(posedge pclk) begin
    gcnt <= (gcnt == 3) ? 0 : gcnt + 1;
    if (gcnt == 3) gclk <= ~gclk;
  end
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wait_done;
    do begin
      apb(1'b0, CSPC_OFS_CMD_STAT, 32'h0);
    end while (q[0] !== 1'b1);
  endtask
  // pclk edges between two rising edges of one channel clock
  task automatic period(input int ch, input int exp);
    int k0;
    logic p;
    k0 = -1;
    p = chclk[ch];
    for (int k = 0; k < 3000; k++) begin
      @(posedge pclk);
      if (chclk[ch] === 1'b1 && p === 1'b0) begin
        if (k0 >= 0) begin
          chk("channel period", k - k0, exp);
          return;
        end
        k0 = k;
      end
      p = chclk[ch];
    end
    chk("channel period", 0, exp);
  endtask
  task automatic results;
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  initial begin
    #2_500_000;
    err_count++;
    results();
  end
  initial begin
    logic [7:0] loc [3] = '{8'h08, 8'h0d, 8'h57};
    logic [7:0] v1 [3] = '{8'ha5, 8'h7e, 8'h5a};
    logic [7:0] v2 [3] = '{8'h3c, 8'h81, 8'hc3};
    int dv [4] = '{0, 1, 0, 2};
    {presetn, psel, penable, pwrite, gclk, paddr, pwdata, nack} = '0;
    {gcnt, err_count, n_compared} = '0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    // reset state, unmapped place, both setting memories
    apb(1'b0, CSPC_OFS_CMD_STAT, 32'h0);
    chk("status after reset", q, 32'h1);
    apb(1'b0, 8'hc0, 32'h0);
    chk("unmapped error", {31'h0, e}, 32'h1);
    for (int i = 0; i < 3; i++) begin
      apb(1'b1, CSPC_OFS_INDEX, {24'h0, loc[i]});
      apb(1'b1, CSPC_OFS_MEM_ONE, {24'hf0f0f0, v1[i]});
      apb(1'b1, CSPC_OFS_MEM_TWO, {24'h0, v2[i]});
    end
    for (int i = 0; i < 3; i++) begin
      apb(1'b1, CSPC_OFS_INDEX, {24'h0, loc[i]});
      apb(1'b0, CSPC_OFS_MEM_ONE, 32'h0);
      chk("memory one", q, {24'h0, v1[i]});
      apb(1'b0, CSPC_OFS_MEM_TWO, 32'h0);
      chk("memory two", q, {24'h0, v2[i]});
    end
    apb(1'b0, CSPC_OFS_INDEX, 32'h0);
    chk("index readback", q, 32'h57);
    $display("test registers finished");
    // a clean load of both chips
    apb(1'b1, CSPC_OFS_IRQ_EN, 32'h7);
    apb(1'b1, CSPC_OFS_CMD_STAT, 32'h1);
    apb(1'b0, CSPC_OFS_CMD_STAT, 32'h0);
    chk("done while loading", {31'h0, q[0]}, 32'h0);
    wait_done();
    chk("error after clean load", {31'h0, q[1]}, 32'h0);
    for (int i = 0; i < 2; i++) begin
      chk("frames", frames[i], 32'd80);
      chk("chip address", {24'h0, fb[i]}, 32'hd2);
    end
    chk("last byte one", {24'h0, lb[0]}, 32'h5a);
    chk("last byte two", {24'h0, lb[1]}, 32'hc3);
    #1;
    chk("irq on done", {31'h0, irq}, 32'h1);
    apb(1'b0, CSPC_OFS_IRQ_STAT, 32'h0);
    chk("irq status", q, 32'h1);
    apb(1'b1, CSPC_OFS_IRQ_CLR, 32'h7);
    #1;
    chk("irq cleared", {31'h0, irq}, 32'h0);
    $display("test load finished");
    // dividers, readback and measurement
    apb(1'b1, CSPC_OFS_CMD_STAT, 32'h002010c0);
    apb(1'b0, CSPC_OFS_CMD_STAT, 32'h0);
    chk("readback", {8'h0, q[31:8]}, 32'h2010c0);
    for (int i = 0; i < 4; i++) period(i, 8 << dv[i]);
    apb(1'b1, CSPC_OFS_CMD_STAT, 32'h00501040);
    period(1, 16);
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, CSPC_OFS_CMD_STAT, 32'h2 << i);
      apb(1'b0, CSPC_OFS_CMD_STAT, 32'h0);
      chk("measuring", {31'h0, q[2]}, 32'h0);
      for (int n = 0; n < 200 && q[2] !== 1'b1; n++) apb(1'b0, CSPC_OFS_CMD_STAT, 32'h0);
      chk("measured value", {8'h0, q[31:8]}, GATE / (8 << dv[i]));
    end
    $display("test dividers finished");
    // first chip refuses, error then masking and clearing by a new load
    nack <= 2'b01;
    apb(1'b1, CSPC_OFS_CMD_STAT, 32'h1);
    wait_done();
    chk("load error", {31'h0, q[1]}, 32'h1);
    #1;
    chk("irq on error", {31'h0, irq}, 32'h1);
    apb(1'b1, CSPC_OFS_IRQ_EN, 32'h0);
    #1;
    chk("irq masked", {31'h0, irq}, 32'h0);
    nack <= 2'b00;
    apb(1'b1, CSPC_OFS_CMD_STAT, 32'h1);
    apb(1'b0, CSPC_OFS_CMD_STAT, 32'h0);
    chk("error after reload", {30'h0, q[1:0]}, 32'h0);
    $display("test error finished");
    results();
  end
endmodule
